// file: src/mix_gain_pkg.sv
/*
  Constants shared by the mix/miscellaneous and output gain register bank:
  register offsets, field positions, reset values, write masks, timing.
  Assumes a 100 MHz system clock and a 16-bit register data path.
*/
`default_nettype none

package mix_gain_pkg;

  // ==========================================================================
  // Register bus
  localparam int          ADDR_W         = 5;
  localparam int          DATA_W         = 16;
  localparam logic [4:0]  ADDR_POWER     = 5'h00;
  localparam logic [4:0]  ADDR_MISC      = 5'h08;
  localparam logic [4:0]  ADDR_OUT1_GAIN = 5'h09;
  localparam logic [4:0]  ADDR_OUT2_GAIN = 5'h0A;
  localparam logic [4:0]  ADDR_ANALOG_EN = 5'h1B;

  // ==========================================================================
  // Reset values and writable bits
  localparam logic [15:0] MISC_DEFAULT      = 16'h8868;
  localparam logic [15:0] MISC_WRITE_MASK   = 16'h9FFB;
  localparam logic [15:0] GAIN_DEFAULT      = 16'h8888;
  localparam logic [15:0] GAIN_WRITE_MASK   = 16'hBFBF;
  localparam logic        POWERDOWN_DEFAULT = 1'b0;
  localparam logic [3:0]  ANALOG_EN_DEFAULT = 4'hF;
  localparam logic [7:0]  UPPER_DEFAULT     = 8'h88;

  // ==========================================================================
  // Field positions
  localparam int MISC_MONO_IN_MUTE = 15;
  localparam int MISC_GAIN_LSB     = 8;
  localparam int MISC_GAIN_W       = 5;
  localparam int MISC_GLOBAL_MUTE  = 7;
  localparam int MISC_MONO_OUT     = 6;
  localparam int MISC_HP_MUTE      = 5;
  localparam int MISC_HP_SWING     = 4;
  localparam int MISC_SUM_MUTE     = 3;
  localparam int MISC_OUT2_TIMING  = 1;
  localparam int MISC_OUT1_TIMING  = 0;
  localparam int UPPER_LSB         = 8;
  localparam int GAIN_LEFT_MUTE    = 15;
  localparam int GAIN_LEFT_LSB     = 8;
  localparam int GAIN_RIGHT_MUTE   = 7;
  localparam int GAIN_RIGHT_LSB    = 0;
  localparam int GAIN_FIELD_W      = 6;
  localparam int POWER_PDN         = 0;
  localparam int EN_MIX            = 0;
  localparam int EN_CHAN           = 1;
  localparam int EN_OUT1           = 2;
  localparam int EN_OUT2           = 3;
  localparam int EN_W              = 4;
  localparam int MIX_PATHS         = 5;

  // ==========================================================================
  // Mono mix gain in tenths of a dB
  localparam int         DB_W             = 10;
  localparam logic [9:0] GAIN_TOP_TENTHS  = 10'h078;
  localparam logic [9:0] GAIN_STEP_TENTHS = 10'h00F;

  // ==========================================================================
  // Deferred gain change timeout
  localparam int COUNT_W                = 20;
  localparam int CLK_KHZ                = 32'h0001_86A0;
  localparam int TIMEOUT_MS             = 32'h0000_000A;
  localparam int TIMEOUT_CYCLES_DEFAULT = TIMEOUT_MS * CLK_KHZ;

endpackage : mix_gain_pkg

`default_nettype wire

// file: src/pin_sync.sv
/*
  Three-stage synchroniser with agreement filter for one asynchronous pin.
  Assumes the pin may change at any time relative to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic async_in,
  output logic      level,
  output logic      changed
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic changed;
    logic [3:0] fill;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // ==========================================================================
  // Level moves only when stages two and three agree
  always_comb begin
    next_st         = st;
    next_st.s1      = async_in;
    next_st.s2      = st.s1;
    next_st.s3      = st.s2;
    next_st.changed = 1'b0;
    // No pulse until the stages hold real samples after reset
    next_st.fill    = {st.fill[2:0], 1'b1};
    if (st.s2 == st.s3 && st.s3 != st.level) begin
      next_st.level   = st.s3;
      next_st.changed = st.fill[3];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '{s1: RESET_LEVEL, s2: RESET_LEVEL, s3: RESET_LEVEL,
              level: RESET_LEVEL, changed: 1'b0, fill: '0};
    end else begin
      st <= next_st;
    end
  end

  assign level   = st.level;
  assign changed = st.changed;

endmodule : pin_sync

`default_nettype wire

// file: src/gain_change_timer.sv
/*
  Holds a written output gain word and applies it to the active setting,
  either at once or at the next zero crossing or timeout.
  Assumes write values arrive already masked and clear is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module gain_change_timer
  import mix_gain_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYCLES_DEFAULT
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        clear,
  input  wire logic        write_strobe,
  input  wire logic [15:0] write_value,
  input  wire logic        immediate,
  input  wire logic        zero_event,
  output logic      [15:0] written_value,
  output logic      [15:0] active_value,
  output logic             pending
);

  localparam logic [COUNT_W-1:0] TIMEOUT_LAST = COUNT_W'(TIMEOUT_CYCLES - 1);

  typedef struct packed {
    logic [15:0]        written;
    logic [15:0]        active;
    logic               armed;
    logic [COUNT_W-1:0] count;
  } timer_state_t;

  timer_state_t st;
  timer_state_t next_st;

  // ==========================================================================
  // Write restarts the wait; a new write wins over a same-cycle event
  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.written = GAIN_DEFAULT;
      next_st.active  = GAIN_DEFAULT;
      next_st.armed   = 1'b0;
      next_st.count   = '0;
    end else if (write_strobe) begin
      next_st.written = write_value;
      next_st.count   = '0;
      if (immediate) begin
        next_st.active = write_value;
        next_st.armed  = 1'b0;
      end else begin
        next_st.armed = 1'b1;
      end
    end else if (st.armed) begin
      if (immediate || zero_event || st.count == TIMEOUT_LAST) begin
        next_st.active = st.written;
        next_st.armed  = 1'b0;
        next_st.count  = '0;
      end else begin
        next_st.count = st.count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '{written: GAIN_DEFAULT, active: GAIN_DEFAULT, armed: 1'b0, count: '0};
    end else begin
      st <= next_st;
    end
  end

  assign written_value = st.written;
  assign active_value  = st.active;
  assign pending       = st.armed;

endmodule : gain_change_timer

`default_nettype wire

// file: src/mix_misc_and_dac1_gain_regs.sv
/*
  Mono mix / miscellaneous control register and output gain registers of a
  serial-port audio codec, with power gating and deferred gain changes.
  Assumes a same-clock register port; zero-crossing comparators and the
  powerdown pin are asynchronous and get synchronised here.
*/
// Overview of operation
// - Misc register resets to 8868 hex
// - Reset, powerdown pin or bit force default
// - Upper byte locked when mix/channel disabled
// - First output gain: immediate or deferred change
// - Second output gain: immediate or deferred change
// - Sum mute bit mutes sum inputs mix
// - Swing bit selects 2 or 4 volt
// - Headphone mute bit mutes both headphones
// - Mono output mute bit mutes mono out
// - Global mute overrides all mix path mutes
// - Mono gain: +12 dB minus 1.5 per step
// - Gain word: mute and 6-bit gain per side
// - Mono input mix mute bit mutes mono mix
`timescale 1ns/1ps
`default_nettype none

module mix_misc_and_dac1_gain_regs #(
  parameter int TIMEOUT_CYCLES = mix_gain_pkg::TIMEOUT_CYCLES_DEFAULT
) (
  input  wire logic                               clk,
  input  wire logic                               resetn,
  input  wire logic                               powerdown_pin_n,
  input  wire logic                               out1_zero_cross,
  input  wire logic                               out2_zero_cross,
  input  wire logic [mix_gain_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [mix_gain_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                               reg_write,
  input  wire logic                               reg_read,
  output logic      [mix_gain_pkg::DATA_W-1:0]    reg_rdata,
  input  wire logic [mix_gain_pkg::MIX_PATHS-1:0] mix_path_mute_request,
  output logic      [mix_gain_pkg::MIX_PATHS-1:0] mix_path_mute,
  output logic                                    mono_input_mix_mute,
  output logic      [mix_gain_pkg::MISC_GAIN_W-1:0] mono_mix_gain,
  output logic      [mix_gain_pkg::DB_W-1:0]      mono_mix_gain_tenth_db,
  output logic                                    global_mix_mute,
  output logic                                    mono_output_mute,
  output logic                                    headphone_mute,
  output logic                                    headphone_swing_select,
  output logic                                    sum_input_mix_mute,
  output logic                                    first_output_change_timing,
  output logic                                    second_output_change_timing,
  output logic                                    left_out1_mute,
  output logic      [mix_gain_pkg::GAIN_FIELD_W-1:0] left_out1_gain,
  output logic                                    right_out1_mute,
  output logic      [mix_gain_pkg::GAIN_FIELD_W-1:0] right_out1_gain,
  output logic                                    left_out2_mute,
  output logic      [mix_gain_pkg::GAIN_FIELD_W-1:0] left_out2_gain,
  output logic                                    right_out2_mute,
  output logic      [mix_gain_pkg::GAIN_FIELD_W-1:0] right_out2_gain
);

  import mix_gain_pkg::*;

  typedef struct packed {
    logic [15:0]          misc;
    logic                 pdn;
    logic [EN_W-1:0]      en;
    logic [15:0]          rdata;
    logic [MIX_PATHS-1:0] path_mute;
    logic [DB_W-1:0]      gain_db;
  } top_state_t;

  top_state_t  st;
  top_state_t  next_st;
  logic        pin_up;
  logic        zero1;
  logic        zero2;
  logic        full_clear;
  logic        upper_clear;
  logic        out1_clear;
  logic        out2_clear;
  logic        out1_write;
  logic        out2_write;
  logic [15:0] out1_written;
  logic [15:0] out1_active;
  logic [15:0] out2_written;
  logic [15:0] out2_active;
  logic        out1_pending;
  logic        out2_pending;

  function automatic logic [DB_W-1:0] mono_gain_tenths(input logic [MISC_GAIN_W-1:0] code);
    mono_gain_tenths = GAIN_TOP_TENTHS - DB_W'(GAIN_STEP_TENTHS * {5'h00, code});
  endfunction : mono_gain_tenths

  // ==========================================================================
  // Asynchronous inputs
  pin_sync #(.RESET_LEVEL(1'b1)) u_pdn_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (powerdown_pin_n),
    .level    (pin_up),
    .changed  ()
  );

  pin_sync #(.RESET_LEVEL(1'b0)) u_zero1_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (out1_zero_cross),
    .level    (),
    .changed  (zero1)
  );

  pin_sync #(.RESET_LEVEL(1'b0)) u_zero2_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (out2_zero_cross),
    .level    (),
    .changed  (zero2)
  );

  // ==========================================================================
  // Power gating of the registers
  always_comb begin
    full_clear  = !pin_up || st.pdn;
    upper_clear = full_clear || !st.en[EN_MIX] || !st.en[EN_CHAN];
    out1_clear  = full_clear || !st.en[EN_CHAN] || !st.en[EN_OUT1];
    out2_clear  = full_clear || !st.en[EN_CHAN] || !st.en[EN_OUT2];
    out1_write  = reg_write && reg_addr == ADDR_OUT1_GAIN;
    out2_write  = reg_write && reg_addr == ADDR_OUT2_GAIN;
  end

  // ==========================================================================
  // Output gain words
  gain_change_timer #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_out1_timer (
    .clk           (clk),
    .resetn        (resetn),
    .clear         (out1_clear),
    .write_strobe  (out1_write),
    .write_value   (reg_wdata & GAIN_WRITE_MASK),
    .immediate     (st.misc[MISC_OUT1_TIMING]),
    .zero_event    (zero1),
    .written_value (out1_written),
    .active_value  (out1_active),
    .pending       (out1_pending)
  );

  gain_change_timer #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_out2_timer (
    .clk           (clk),
    .resetn        (resetn),
    .clear         (out2_clear),
    .write_strobe  (out2_write),
    .write_value   (reg_wdata & GAIN_WRITE_MASK),
    .immediate     (st.misc[MISC_OUT2_TIMING]),
    .zero_event    (zero2),
    .written_value (out2_written),
    .active_value  (out2_active),
    .pending       (out2_pending)
  );

  // ==========================================================================
  // Register writes, read decode, derived controls
  always_comb begin
    next_st       = st;
    next_st.rdata = '0;
    if (reg_write && reg_addr == ADDR_POWER) begin
      next_st.pdn = reg_wdata[POWER_PDN];
    end
    if (reg_write && reg_addr == ADDR_ANALOG_EN) begin
      next_st.en = reg_wdata[EN_W-1:0];
    end
    if (full_clear) begin
      next_st.misc = MISC_DEFAULT;
    end else begin
      if (reg_write && reg_addr == ADDR_MISC) begin
        next_st.misc = reg_wdata & MISC_WRITE_MASK;
      end
      if (upper_clear) begin
        next_st.misc[15:UPPER_LSB] = UPPER_DEFAULT;
      end
    end
    if (reg_read) begin
      if (reg_addr == ADDR_POWER) begin
        next_st.rdata = 16'(st.pdn);
      end else if (reg_addr == ADDR_MISC) begin
        next_st.rdata = st.misc;
      end else if (reg_addr == ADDR_OUT1_GAIN) begin
        next_st.rdata = out1_written;
      end else if (reg_addr == ADDR_OUT2_GAIN) begin
        next_st.rdata = out2_written;
      end else if (reg_addr == ADDR_ANALOG_EN) begin
        next_st.rdata = 16'(st.en);
      end
    end
    next_st.path_mute = mix_path_mute_request | {MIX_PATHS{st.misc[MISC_GLOBAL_MUTE]}};
    next_st.gain_db   = mono_gain_tenths(st.misc[MISC_GAIN_LSB +: MISC_GAIN_W]);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '{misc: MISC_DEFAULT, pdn: POWERDOWN_DEFAULT, en: ANALOG_EN_DEFAULT,
              rdata: '0, path_mute: '0, gain_db: '0};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata                   = st.rdata;
  assign mix_path_mute               = st.path_mute;
  assign mono_mix_gain_tenth_db      = st.gain_db;
  assign mono_input_mix_mute         = st.misc[MISC_MONO_IN_MUTE];
  assign mono_mix_gain               = st.misc[MISC_GAIN_LSB +: MISC_GAIN_W];
  assign global_mix_mute             = st.misc[MISC_GLOBAL_MUTE];
  assign mono_output_mute            = st.misc[MISC_MONO_OUT];
  assign headphone_mute              = st.misc[MISC_HP_MUTE];
  assign headphone_swing_select      = st.misc[MISC_HP_SWING];
  assign sum_input_mix_mute          = st.misc[MISC_SUM_MUTE];
  assign first_output_change_timing  = st.misc[MISC_OUT1_TIMING];
  assign second_output_change_timing = st.misc[MISC_OUT2_TIMING];
  assign left_out1_mute              = out1_active[GAIN_LEFT_MUTE];
  assign left_out1_gain              = out1_active[GAIN_LEFT_LSB +: GAIN_FIELD_W];
  assign right_out1_mute             = out1_active[GAIN_RIGHT_MUTE];
  assign right_out1_gain             = out1_active[GAIN_RIGHT_LSB +: GAIN_FIELD_W];
  assign left_out2_mute              = out2_active[GAIN_LEFT_MUTE];
  assign left_out2_gain              = out2_active[GAIN_LEFT_LSB +: GAIN_FIELD_W];
  assign right_out2_mute             = out2_active[GAIN_RIGHT_MUTE];
  assign right_out2_gain             = out2_active[GAIN_RIGHT_LSB +: GAIN_FIELD_W];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_clear_to_default: assert property (
    full_clear |=> st.misc == MISC_DEFAULT)
    else $error("misc register not at default after clear");

  a_upper_byte_locked: assert property (
    upper_clear |=> st.misc[15:UPPER_LSB] == UPPER_DEFAULT)
    else $error("misc upper byte changed while locked");

  a_lower_write_lands: assert property (
    (reg_write && reg_addr == ADDR_MISC && !full_clear)
    |=> st.misc[7:0] == $past(reg_wdata[7:0] & MISC_WRITE_MASK[7:0]))
    else $error("misc lower byte write lost or reserved bit kept");

  a_global_mute_all: assert property (
    st.misc[MISC_GLOBAL_MUTE] |=> mix_path_mute == {MIX_PATHS{1'b1}})
    else $error("global mute did not mute every path");

  a_mono_gain_points: assert property (
    (st.misc[MISC_GAIN_LSB +: MISC_GAIN_W] == 5'h00) |=> mono_mix_gain_tenth_db == 10'h078)
    else $error("mono gain code zero not plus twelve dB");

  a_mono_gain_end: assert property (
    (st.misc[MISC_GAIN_LSB +: MISC_GAIN_W] == 5'h1F) |=> mono_mix_gain_tenth_db == 10'h2A7)
    else $error("mono gain code max not minus 34.5 dB");

  a_out1_immediate: assert property (
    (out1_write && st.misc[MISC_OUT1_TIMING] && !out1_clear)
    |=> out1_active == $past(reg_wdata & GAIN_WRITE_MASK))
    else $error("first output gain not applied at once");

  a_out2_immediate: assert property (
    (out2_write && st.misc[MISC_OUT2_TIMING] && !out2_clear)
    |=> out2_active == $past(reg_wdata & GAIN_WRITE_MASK))
    else $error("second output gain not applied at once");

  a_deferred_holds: assert property (
    (out1_write && !st.misc[MISC_OUT1_TIMING] && !out1_clear)
    |=> $stable(out1_active) && out1_pending)
    else $error("deferred gain applied without crossing or timeout");

  a_crossing_applies: assert property (
    (out1_pending && zero1 && !out1_write && !out1_clear)
    |=> !out1_pending && out1_active == out1_written)
    else $error("zero crossing did not apply pending gain");

  a_read_latency: assert property (
    (reg_read && reg_addr == ADDR_OUT1_GAIN) |=> reg_rdata[14] == 1'b0 && reg_rdata[6] == 1'b0
    ##1 reg_rdata == 16'h0000 || reg_read)
    else $error("gain readback shows reserved bits or stale data");

  a_upper_write_lands: assert property (
    (reg_write && reg_addr == ADDR_MISC && !upper_clear)
    |=> st.misc[15:UPPER_LSB] == $past(reg_wdata[15:UPPER_LSB] & MISC_WRITE_MASK[15:UPPER_LSB]))
    else $error("misc upper byte write lost while unlocked");

  a_mute_follows_request: assert property (
    !st.misc[MISC_GLOBAL_MUTE] |=> mix_path_mute == $past(mix_path_mute_request))
    else $error("path mute differs from request without global mute");

  a_out2_deferred: assert property (
    (out2_write && !st.misc[MISC_OUT2_TIMING] && !out2_clear)
    |=> $stable(out2_active) && out2_pending)
    else $error("second output deferred gain applied early");

  a_out2_crossing: assert property (
    (out2_pending && zero2 && !out2_write && !out2_clear)
    |=> !out2_pending && out2_active == out2_written)
    else $error("zero crossing did not apply second output gain");

  a_clear_drops_pending: assert property (
    out1_clear |=> !out1_pending && out1_active == GAIN_DEFAULT)
    else $error("cleared first output gain kept pending or active value");

endmodule : mix_misc_and_dac1_gain_regs

`default_nettype wire

// file: bench/mix_misc_and_dac1_gain_regs_tb.sv
/*
  Self-checking bench for the mix/misc and output gain register bank.
  Assumes mix_gain_pkg is compiled first and a short gain timeout of 16.
*/
`timescale 1ns/1ps
`default_nettype none

module mix_misc_and_dac1_gain_regs_tb;
  import mix_gain_pkg::*;

  typedef struct {logic [15:0] w; logic [15:0] rd; logic [9:0] db;} row_t;

  localparam int T = 16;

  logic        clk;
  logic        resetn;
  logic        pin_n;
  logic [1:0]  zc;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [15:0] reg_rdata;
  logic [4:0]  req;
  logic [4:0]  mute;
  logic [4:0]  mgain;
  logic [9:0]  db;
  logic [15:0] o1;
  logic [15:0] o2;
  logic [11:0] mbits;
  int          error_cnt;
  int          n_tests;
  row_t        rows [5];

  mix_misc_and_dac1_gain_regs #(.TIMEOUT_CYCLES(T)) dut (
    .clk(clk), .resetn(resetn), .powerdown_pin_n(pin_n),
    .out1_zero_cross(zc[0]), .out2_zero_cross(zc[1]),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .mix_path_mute_request(req), .mix_path_mute(mute),
    .mono_input_mix_mute(mbits[11]), .mono_mix_gain(mgain),
    .mono_mix_gain_tenth_db(db), .global_mix_mute(mbits[7]),
    .mono_output_mute(mbits[6]), .headphone_mute(mbits[5]),
    .headphone_swing_select(mbits[4]), .sum_input_mix_mute(mbits[3]),
    .second_output_change_timing(mbits[1]), .first_output_change_timing(mbits[0]),
    .left_out1_mute(o1[15]), .left_out1_gain(o1[13:8]),
    .right_out1_mute(o1[7]), .right_out1_gain(o1[5:0]),
    .left_out2_mute(o2[15]), .left_out2_gain(o2[13:8]),
    .right_out2_mute(o2[7]), .right_out2_gain(o2[5:0])
  );

  assign {o1[14], o1[6], o2[14], o2[6]} = 4'h0;
  assign {mbits[10:8], mbits[2]} = 4'h0;

  // ==========================================================================
  // Bus and compare tasks
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  task rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    cmp(reg_rdata, exp);
  endtask : rd

  function automatic logic [15:0] act(input int s);
    return s ? o2 : o1;
  endfunction : act

  // Immediate, timeout, crossing and restarted deferral on one output
  task gain_case(input int s);
    logic [4:0] a;
    a = s ? ADDR_OUT2_GAIN : ADDR_OUT1_GAIN;
    wr(ADDR_MISC, 16'h0003);
    wr(a, 16'h3F15);
    cyc(1);
    cmp(act(s), 16'h3F15);
    wr(ADDR_MISC, 16'h0000);
    wr(a, 16'h8001);
    cyc(14);
    cmp(act(s), 16'h3F15);
    cyc(4);
    cmp(act(s), 16'h8001);
    rd(a, 16'h8001);
    wr(a, 16'h0102);
    cyc(2);
    cmp(act(s), 16'h8001);
    @(posedge clk);
    zc[s] <= ~zc[s];
    cyc(8);
    cmp(act(s), 16'h0102);
    wr(a, 16'h0203);
    repeat (8) @(posedge clk);
    wr(a, 16'h0304);
    cyc(14);
    cmp(act(s), 16'h0102);
    cyc(4);
    cmp(act(s), 16'h0304);
    $display("test gain timing output %0d done", s + 1);
  endtask : gain_case

  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // ==========================================================================
  // Clock, watchdog, sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200000;
    error_cnt++;
    conclude();
  end

  initial begin
    resetn = 1'b0; pin_n = 1'b1; zc = 2'b00; reg_addr = 5'h00;
    reg_wdata = 16'h0000; reg_write = 1'b0; reg_read = 1'b0; req = 5'h05;
    error_cnt = 0; n_tests = 0;
    rows[0] = '{16'h0000, 16'h0000, 10'h078};
    rows[1] = '{16'h9FFB, 16'h9FFB, 10'h2A7};
    rows[2] = '{16'h0851, 16'h0851, 10'h000};
    rows[3] = '{16'h04AA, 16'h04AA, 10'h03C};
    rows[4] = '{16'h1000, 16'h1000, 10'h388};
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    cyc(5);
    rd(ADDR_MISC, 16'h8868);
    rd(ADDR_OUT1_GAIN, 16'h8888);
    rd(ADDR_ANALOG_EN, 16'h000F);
    rd(5'h05, 16'h0000);
    $display("test reset values done");
    foreach (rows[i]) begin
      wr(ADDR_MISC, rows[i].w);
      cyc(2);
      cmp({8'h0, mbits[7:0]}, {8'h0, rows[i].rd[7:3], 1'b0, rows[i].rd[1:0]});
      cmp({15'h0, mbits[11]}, {15'h0, rows[i].rd[15]});
      cmp({11'h0, mgain}, {11'h0, rows[i].rd[12:8]});
      cmp({6'h0, db}, {6'h0, rows[i].db});
      cmp({11'h0, mute}, rows[i].rd[7] ? 16'h001F : 16'h0005);
      rd(ADDR_MISC, rows[i].rd);
    end
    $display("test misc fields done");
    wr(ADDR_OUT1_GAIN, 16'hBFBF);
    rd(ADDR_OUT1_GAIN, 16'hBFBF);
    wr(ADDR_ANALOG_EN, 16'h000E);
    wr(ADDR_MISC, 16'h1111);
    rd(ADDR_MISC, 16'h8811);
    wr(ADDR_ANALOG_EN, 16'h000F);
    $display("test upper byte lock done");
    wr(ADDR_MISC, 16'h0011);
    pin_n <= 1'b0;
    cyc(6);
    rd(ADDR_MISC, 16'h8868);
    wr(ADDR_MISC, 16'h0022);
    pin_n <= 1'b1;
    cyc(6);
    rd(ADDR_MISC, 16'h8868);
    wr(ADDR_MISC, 16'h0011);
    wr(ADDR_POWER, 16'h0001);
    rd(ADDR_MISC, 16'h8868);
    wr(ADDR_MISC, 16'h0022);
    wr(ADDR_POWER, 16'h0000);
    rd(ADDR_MISC, 16'h8868);
    $display("test powerdown clearing done");
    gain_case(0);
    gain_case(1);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    cyc(5);
    rd(ADDR_MISC, 16'h8868);
    rd(ADDR_OUT2_GAIN, 16'h8888);
    $display("test second reset done");
    conclude();
  end

endmodule : mix_misc_and_dac1_gain_regs_tb

`default_nettype wire
